/* verilog/scu_regs.vh */
// Constants of the serial communication unit
`ifndef SCU_REGS_VH
`define SCU_REGS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SCU_CLK_HZ     40000000
`define SCU_SCL_HZ     40000
// Quarter of an SCL period in clock cycles, sized for the 16-bit counter
`define SCU_QTR_CYC    16'h00fa
`define SCU_BAUD_HZ    115200
// One UART bit time in clock cycles, sized for the 16-bit counter
`define SCU_BIT_CYC    16'h015b
`define SCU_UART_BITS  4'h9
`define SCU_LAST_BIT   3'h7

// ----------------------------------------
// Operating modes
// ----------------------------------------
`define SCU_MODE_I2C   2'h0
`define SCU_MODE_UART  2'h1
`define SCU_MODE_SPI   2'h2

// ----------------------------------------
// Event flag positions
// ----------------------------------------
`define SCU_F_START    0
`define SCU_F_STOP     1
`define SCU_F_NACK     2

// ----------------------------------------
// Bus phases
// ----------------------------------------
`define SCU_PH_DATA    2'h0
`define SCU_PH_SETUP   2'h1
`define SCU_PH_RISE    2'h2
`define SCU_PH_HIGH    2'h3

`endif

/* verilog/scu_serial_unit.v */
// Serial unit: I2C master, UART receive busy, SPI slave transmit
// Function
// - Multi-master select waits for a free bus; transmitter select enables sending.
// - With multi-master select, a start request on a busy bus waits in ST_WAIT, then starts once bus frees.
// - Start request stays set until START is on the bus, then reads zero.
// - Start, stop and no-ack flags clear on bus events or by software.
// - Flag with enable pends; it is taken when global enable is set.
// - In UART mode busy flag is high while a character is received.
// - Soft reset bit holds the unit in reset; clearing releases it.
// - SPI slave supports clock phase one; bit order follows MSB select.
// - Writing the transmit buffer preloads the transmit shift register.
// - Transmit buffer reads back the last written value.
`include "scu_regs.vh"
`default_nettype none

module scu_serial_unit (
    // Clock and reset
    input  wire       CLOCK,
    input  wire       ARST_N,
    // Control
    input  wire       SOFT_RESET,
    input  wire [1:0] MODE,
    input  wire       MULTI_MASTER_SELECT,
    input  wire       TRANSMITTER_SELECT,
    input  wire       START_REQUEST_SET,
    input  wire       STOP_REQUEST_SET,
    input  wire       MSB_FIRST_SELECT,
    input  wire       CLOCK_PHASE_SELECT,
    // Event flags and interrupt gating
    input  wire [2:0] FLAG_CLEAR,
    input  wire [2:0] IRQ_EN,
    input  wire       GLOBAL_IRQ_ENABLE,
    // Status
    output reg        START_REQUEST,
    output reg        STOP_REQUEST,
    output reg        BUS_BUSY_FLAG,
    output reg        UNIT_BUSY_FLAG,
    output reg  [2:0] EVENT_FLAGS,
    output reg  [2:0] IRQ_PENDING,
    output reg        IRQ_TAKEN,
    // I2C transmit data stream
    input  wire [7:0] TX_DATA,
    input  wire       TX_VALID,
    output reg        TX_READY,
    // I2C pins
    input  wire       SCL_IN,
    output reg        SCL_OUT,
    output reg        SCL_OE,
    input  wire       SDA_IN,
    output reg        SDA_OUT,
    output reg        SDA_OE,
    // UART pin
    input  wire       UART_RX,
    // SPI slave transmit
    input  wire       SPI_CLK,
    output reg        SPI_MISO,
    input  wire       TXB_WRITE,
    input  wire [7:0] TXB_DATA,
    output reg  [7:0] TXB_READBACK
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [2:0] ST_IDLE  = 3'h0;
localparam [2:0] ST_WAIT  = 3'h1;
localparam [2:0] ST_START = 3'h2;
localparam [2:0] ST_LOAD  = 3'h3;
localparam [2:0] ST_BIT   = 3'h4;
localparam [2:0] ST_ACK   = 3'h5;
localparam [2:0] ST_STOP  = 3'h6;

// ----------------------------------------
// Functions
// ----------------------------------------
function out_bit;
    input [7:0] sh;
    input       msb;
    begin
        out_bit = msb ? sh[7] : sh[0];
    end
endfunction

function [7:0] shift_on;
    input [7:0] sh;
    input       msb;
    begin
        shift_on = msb ? {sh[6:0], 1'b0} : {1'b0, sh[7:1]};
    end
endfunction

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
reg  [1:0] scl_m;
reg  [1:0] sda_m;
reg  [1:0] rx_m;
reg  [1:0] sck_m;
reg        scl_d;
reg        sda_d;
reg        rx_d;
reg        sck_d;
wire       scl_s = scl_m[1];
wire       sda_s = sda_m[1];
wire       rx_s  = rx_m[1];
wire       sck_s = sck_m[1];

always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        scl_m <= 2'h3;
        sda_m <= 2'h3;
        rx_m  <= 2'h3;
        sck_m <= 2'h0;
        scl_d <= 1'b1;
        sda_d <= 1'b1;
        rx_d  <= 1'b1;
        sck_d <= 1'b0;
    end else begin
        scl_m <= {scl_m[0], SCL_IN};
        sda_m <= {sda_m[0], SDA_IN};
        rx_m  <= {rx_m[0], UART_RX};
        sck_m <= {sck_m[0], SPI_CLK};
        scl_d <= scl_s;
        sda_d <= sda_s;
        rx_d  <= rx_s;
        sck_d <= sck_s;
    end
end

wire bus_start = scl_s && scl_d && sda_d && !sda_s;
wire bus_stop  = scl_s && scl_d && !sda_d && sda_s;

// ----------------------------------------
// Bus monitor and event flags
// ----------------------------------------
reg        nack_evt;
reg  [2:0] next_flags;

always @* begin
    next_flags = EVENT_FLAGS & ~FLAG_CLEAR;
    if (bus_stop)
        next_flags[`SCU_F_START] = 1'b0;
    if (bus_start) begin
        next_flags[`SCU_F_STOP] = 1'b0;
        next_flags[`SCU_F_NACK] = 1'b0;
    end
    if (bus_start)
        next_flags[`SCU_F_START] = 1'b1;
    if (bus_stop)
        next_flags[`SCU_F_STOP] = 1'b1;
    if (nack_evt)
        next_flags[`SCU_F_NACK] = 1'b1;
end

always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        BUS_BUSY_FLAG <= 1'b0;
        EVENT_FLAGS   <= 3'h0;
        IRQ_PENDING   <= 3'h0;
        IRQ_TAKEN     <= 1'b0;
    end else if (SOFT_RESET) begin
        BUS_BUSY_FLAG <= 1'b0;
        EVENT_FLAGS   <= 3'h0;
        IRQ_PENDING   <= 3'h0;
        IRQ_TAKEN     <= 1'b0;
    end else begin
        if (bus_start)
            BUS_BUSY_FLAG <= 1'b1;
        else if (bus_stop)
            BUS_BUSY_FLAG <= 1'b0;
        EVENT_FLAGS <= next_flags;
        IRQ_PENDING <= next_flags & IRQ_EN;
        IRQ_TAKEN   <= |(next_flags & IRQ_EN) && GLOBAL_IRQ_ENABLE;
    end
end

// ----------------------------------------
// Two-entry transmit buffer
// ----------------------------------------
reg  [7:0] buf0;
reg  [7:0] buf1;
reg  [1:0] cnt;
reg        pop;
wire       push = TX_VALID && TX_READY;
reg  [1:0] next_cnt;

always @* begin
    next_cnt = cnt;
    if (push && !pop)
        next_cnt = cnt + 2'h1;
    else if (pop && !push)
        next_cnt = cnt - 2'h1;
end

always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        buf0     <= 8'h00;
        buf1     <= 8'h00;
        cnt      <= 2'h0;
        TX_READY <= 1'b0;
    end else if (SOFT_RESET) begin
        cnt      <= 2'h0;
        TX_READY <= 1'b0;
    end else begin
        if (pop)
            buf0 <= buf1;
        if (push && (next_cnt == 2'h1))
            buf0 <= TX_DATA;
        if (push && (next_cnt == 2'h2))
            buf1 <= TX_DATA;
        cnt      <= next_cnt;
        TX_READY <= (next_cnt != 2'h2);
    end
end

// ----------------------------------------
// I2C master sequencer
// ----------------------------------------
reg  [2:0]  st;
reg  [1:0]  ph;
reg  [15:0] q;
reg  [2:0]  bitn;
reg  [7:0]  shreg;
wire        tick = (q == 16'h0000);
wire        last = tick && (ph == `SCU_PH_HIGH);

always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        st            <= ST_IDLE;
        ph            <= `SCU_PH_DATA;
        q             <= 16'h0000;
        bitn          <= 3'h0;
        shreg         <= 8'h00;
        pop           <= 1'b0;
        nack_evt      <= 1'b0;
        START_REQUEST <= 1'b0;
        STOP_REQUEST  <= 1'b0;
        SCL_OUT       <= 1'b0;
        SCL_OE        <= 1'b0;
        SDA_OUT       <= 1'b0;
        SDA_OE        <= 1'b0;
    end else if (SOFT_RESET) begin
        st            <= ST_IDLE;
        ph            <= `SCU_PH_DATA;
        q             <= 16'h0000;
        pop           <= 1'b0;
        nack_evt      <= 1'b0;
        START_REQUEST <= 1'b0;
        STOP_REQUEST  <= 1'b0;
        SCL_OE        <= 1'b0;
        SDA_OE        <= 1'b0;
    end else begin
        pop      <= 1'b0;
        nack_evt <= 1'b0;
        q        <= tick ? (`SCU_QTR_CYC - 16'h0001) : (q - 16'h0001);
        if (tick && (st != ST_IDLE) && (st != ST_WAIT) && (st != ST_LOAD))
            ph <= ph + 2'h1;
        if (START_REQUEST_SET && (MODE == `SCU_MODE_I2C) && TRANSMITTER_SELECT)
            START_REQUEST <= 1'b1;
        if (STOP_REQUEST_SET)
            STOP_REQUEST <= 1'b1;
        case (st)
            ST_IDLE: begin
                SCL_OE <= 1'b0;
                SDA_OE <= 1'b0;
                ph     <= `SCU_PH_DATA;
                if (!START_REQUEST && !STOP_REQUEST_SET)
                    STOP_REQUEST <= 1'b0;
                if (START_REQUEST) begin
                    if (MULTI_MASTER_SELECT && BUS_BUSY_FLAG)
                        st <= ST_WAIT;
                    else
                        st <= ST_START;
                end
            end
            ST_WAIT: begin
                ph <= `SCU_PH_DATA;
                if (!BUS_BUSY_FLAG)
                    st <= ST_START;
            end
            ST_START: begin
                SDA_OE <= 1'b1;
                if (tick && (ph == `SCU_PH_SETUP)) begin
                    SCL_OE        <= 1'b1;
                    START_REQUEST <= 1'b0;
                    st            <= ST_LOAD;
                end
            end
            ST_LOAD: begin
                SCL_OE <= 1'b1;
                ph     <= `SCU_PH_DATA;
                if (STOP_REQUEST) begin
                    st <= ST_STOP;
                end else if ((cnt != 2'h0) && !pop) begin
                    shreg <= buf0;
                    pop   <= 1'b1;
                    bitn  <= 3'h0;
                    st    <= ST_BIT;
                end
            end
            ST_BIT: begin
                if (ph == `SCU_PH_DATA)
                    SDA_OE <= ~shreg[7];
                if (tick && (ph == `SCU_PH_SETUP))
                    SCL_OE <= 1'b0;
                if (last) begin
                    SCL_OE <= 1'b1;
                    if (!SDA_OE && !sda_s) begin
                        st     <= ST_IDLE;
                        SCL_OE <= 1'b0;
                    end else begin
                        shreg <= shift_on(shreg, 1'b1);
                        bitn  <= bitn + 3'h1;
                        if (bitn == `SCU_LAST_BIT)
                            st <= ST_ACK;
                    end
                end
            end
            ST_ACK: begin
                SDA_OE <= 1'b0;
                if (tick && (ph == `SCU_PH_SETUP))
                    SCL_OE <= 1'b0;
                if (last) begin
                    SCL_OE <= 1'b1;
                    if (sda_s) begin
                        nack_evt <= 1'b1;
                        st       <= ST_STOP;
                    end else begin
                        st <= ST_LOAD;
                    end
                end
            end
            ST_STOP: begin
                if (ph == `SCU_PH_DATA)
                    SDA_OE <= 1'b1;
                if (tick && (ph == `SCU_PH_SETUP))
                    SCL_OE <= 1'b0;
                if (tick && (ph == `SCU_PH_RISE))
                    SDA_OE <= 1'b0;
                if (last) begin
                    STOP_REQUEST <= STOP_REQUEST_SET;
                    st           <= ST_IDLE;
                end
            end
            default: begin
                st <= ST_IDLE;
            end
        endcase
    end
end

// ----------------------------------------
// UART receive busy
// ----------------------------------------
reg        rx_busy;
reg  [3:0] rx_bits;
reg  [15:0] rx_q;

always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        rx_busy        <= 1'b0;
        rx_bits        <= 4'h0;
        rx_q           <= 16'h0000;
        UNIT_BUSY_FLAG <= 1'b0;
    end else if (SOFT_RESET) begin
        rx_busy        <= 1'b0;
        rx_bits        <= 4'h0;
        rx_q           <= 16'h0000;
        UNIT_BUSY_FLAG <= 1'b0;
    end else begin
        if (!rx_busy) begin
            if ((MODE == `SCU_MODE_UART) && rx_d && !rx_s) begin
                rx_busy <= 1'b1;
                rx_bits <= 4'h0;
                rx_q    <= `SCU_BIT_CYC - 16'h0001;
            end
        end else if (rx_q != 16'h0000) begin
            rx_q <= rx_q - 16'h0001;
        end else begin
            rx_q    <= `SCU_BIT_CYC - 16'h0001;
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits == `SCU_UART_BITS)
                rx_busy <= 1'b0;
        end
        if (MODE == `SCU_MODE_UART)
            UNIT_BUSY_FLAG <= rx_busy;
        else
            UNIT_BUSY_FLAG <= (st != ST_IDLE) || BUS_BUSY_FLAG;
    end
end

// ----------------------------------------
// SPI slave transmit
// ----------------------------------------
reg  [7:0] spi_sh;
wire       sck_lead  = sck_s && !sck_d;
wire       sck_trail = !sck_s && sck_d;

always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        spi_sh       <= 8'h00;
        SPI_MISO     <= 1'b0;
        TXB_READBACK <= 8'h00;
    end else if (SOFT_RESET) begin
        spi_sh   <= 8'h00;
        SPI_MISO <= 1'b0;
    end else if (TXB_WRITE) begin
        TXB_READBACK <= TXB_DATA;
        spi_sh       <= TXB_DATA;
        if (!CLOCK_PHASE_SELECT)
            SPI_MISO <= out_bit(TXB_DATA, MSB_FIRST_SELECT);
    end else if (MODE == `SCU_MODE_SPI) begin
        if (CLOCK_PHASE_SELECT && sck_lead) begin
            SPI_MISO <= out_bit(spi_sh, MSB_FIRST_SELECT);
            spi_sh   <= shift_on(spi_sh, MSB_FIRST_SELECT);
        end
        if (!CLOCK_PHASE_SELECT && sck_trail) begin
            spi_sh   <= shift_on(spi_sh, MSB_FIRST_SELECT);
            SPI_MISO <= out_bit(shift_on(spi_sh, MSB_FIRST_SELECT), MSB_FIRST_SELECT);
        end
    end
end

endmodule // scu_serial_unit

`default_nettype wire

/* verif/scu_serial_unit_asserts.sv */
// Port checker of the serial unit
`default_nettype none
module scu_serial_unit_asserts (
    // Clock and reset
    input wire logic       CLOCK,
    input wire logic       ARST_N,
    input wire logic       SOFT_RESET,
    // Control
    input wire logic [1:0] MODE,
    input wire logic       MULTI_MASTER_SELECT,
    input wire logic       TRANSMITTER_SELECT,
    input wire logic       START_REQUEST_SET,
    input wire logic [2:0] IRQ_EN,
    input wire logic       GLOBAL_IRQ_ENABLE,
    input wire logic       UART_RX,
    input wire logic       TXB_WRITE,
    input wire logic [7:0] TXB_DATA,
    // Status and pins
    input wire logic       START_REQUEST,
    input wire logic       STOP_REQUEST,
    input wire logic       BUS_BUSY_FLAG,
    input wire logic       UNIT_BUSY_FLAG,
    input wire logic [2:0] EVENT_FLAGS,
    input wire logic [2:0] IRQ_PENDING,
    input wire logic       IRQ_TAKEN,
    input wire logic       SCL_IN,
    input wire logic       SDA_IN,
    input wire logic       SCL_OE,
    input wire logic       SDA_OE,
    input wire logic [7:0] TXB_READBACK
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N || SOFT_RESET);
    // ----------------------------------------
    // Bus events
    // ----------------------------------------
    sequence bus_start_s; $fell(SDA_IN) && SCL_IN && $past(SCL_IN); endsequence
    sequence bus_stop_s; $rose(SDA_IN) && SCL_IN && $past(SCL_IN); endsequence
    sequence start_ask_s; START_REQUEST_SET && MODE == 2'h0 && TRANSMITTER_SELECT; endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    start_take_a: assert property (start_ask_s |=> START_REQUEST)
        else $error("start request not taken");
    bus_wait_a: assert property (BUS_BUSY_FLAG [*3] ##0 (START_REQUEST &&
        MULTI_MASTER_SELECT && !SDA_OE) |=> !SDA_OE) else $error("start on busy bus");
    start_hold_a: assert property (START_REQUEST && !SDA_OE |=> START_REQUEST)
        else $error("start request dropped early");
    start_sent_a: assert property ($fell(START_REQUEST) |-> SDA_OE && SCL_OE)
        else $error("start request dropped without start");
    start_flag_a: assert property (bus_start_s |-> ##[1:6] EVENT_FLAGS[0] &&
        !EVENT_FLAGS[1]) else $error("start event flags wrong");
    stop_flag_a: assert property (bus_stop_s |-> ##[1:6] EVENT_FLAGS[1] &&
        !EVENT_FLAGS[0]) else $error("stop event flags wrong");
    irq_pend_a: assert property (IRQ_PENDING == (EVENT_FLAGS & $past(IRQ_EN)))
        else $error("pending mismatch");
    irq_take_a: assert property (IRQ_TAKEN == (|IRQ_PENDING && $past(GLOBAL_IRQ_ENABLE)))
        else $error("taken mismatch");
    rx_busy_a: assert property (MODE == 2'h1 && $fell(UART_RX) && !UNIT_BUSY_FLAG
        |-> ##4 UNIT_BUSY_FLAG [*8]) else $error("receive busy missing");
    txb_load_a: assert property (TXB_WRITE |=> TXB_READBACK == $past(TXB_DATA))
        else $error("transmit buffer not loaded");
    txb_keep_a: assert property (!TXB_WRITE |=> $stable(TXB_READBACK))
        else $error("transmit buffer changed");
    soft_hold_a: assert property (disable iff (!ARST_N) SOFT_RESET [*2] |->
        !START_REQUEST && !SDA_OE && !SCL_OE && !UNIT_BUSY_FLAG) else $error("not held");
    stop_end_a: assert property ($fell(STOP_REQUEST) |-> !SDA_OE && !SCL_OE)
        else $error("bus not released after stop");
endmodule // scu_serial_unit_asserts
bind scu_serial_unit scu_serial_unit_asserts u_asserts (.*);
`default_nettype wire

/* verif/scu_i2c_partner.sv */
// Model of a receiving station on the shared two-wire bus
`default_nettype none
module scu_i2c_partner (
    // Bus wires
    input  wire logic        scl,
    input  wire logic        sda,
    // Behaviour
    input  wire logic        nack,
    input  wire logic [15:0] stretch,
    // Pull-downs and received data
    output var  logic        scl_oe,
    output var  logic        sda_oe,
    output var  logic [7:0]  got,
    output var  int          nbytes
);
    timeunit 1ns;
    timeprecision 1ps;
    int         bits = 0;
    logic [7:0] sh = 8'h00;
    initial begin
        scl_oe = 0;
        sda_oe = 0;
        got = 8'h00;
        nbytes = 0;
    end
    // Start restarts the count
    always @(negedge sda) if (scl) bits = 0;
    always @(posedge scl) begin
        bits = bits + 1;
        if (bits <= 8) sh = {sh[6:0], sda};
    end
    // Acknowledge slot, low phase stretched
    always @(negedge scl) begin
        if (bits == 8) begin
            got = sh;
            sda_oe = !nack;
            nbytes = nbytes + 1;
            scl_oe = stretch != 16'h0;
            #(stretch);
            scl_oe = 0;
        end else if (bits == 9) begin
            sda_oe = 0;
            bits = 0;
        end
    end
endmodule // scu_i2c_partner
`default_nettype wire

/* verif/tb_scu_serial_unit.sv */
// Self-checking bench of the serial unit
`default_nettype none
module tb_scu_serial_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic       CLOCK = 0, ARST_N = 0, SOFT_RESET = 0, MULTI_MASTER_SELECT = 1;
    logic [1:0] MODE = 2'h0;
    logic       TRANSMITTER_SELECT = 0, START_REQUEST_SET = 0, STOP_REQUEST_SET = 0;
    logic       MSB_FIRST_SELECT = 1, CLOCK_PHASE_SELECT = 1, GLOBAL_IRQ_ENABLE = 0;
    logic [2:0] FLAG_CLEAR = 3'h0, IRQ_EN = 3'h0, EVENT_FLAGS, IRQ_PENDING;
    logic       START_REQUEST, STOP_REQUEST, BUS_BUSY_FLAG, UNIT_BUSY_FLAG, IRQ_TAKEN;
    logic [7:0] TX_DATA = 8'h00, TXB_DATA = 8'h00, TXB_READBACK, p_got, b, got;
    logic       TX_VALID = 0, TX_READY, TXB_WRITE = 0, UART_RX = 1, SPI_CLK = 0, SPI_MISO;
    logic       SCL_IN, SCL_OUT, SCL_OE, SDA_IN, SDA_OUT, SDA_OE;
    logic       om_scl = 0, om_sda = 0, p_scl, p_sda, nack = 0;
    logic [15:0] stretch = 16'h0;
    int         p_n, n_errors = 0, checks_done = 0, cycles = 0, seed = 98405, i, k;
    int         sent[$];
    // Open-drain wires with pull-ups
    assign SCL_IN = !(SCL_OE | om_scl | p_scl);
    assign SDA_IN = !(SDA_OE | om_sda | p_sda);
    scu_serial_unit dut (.*);
    scu_i2c_partner u_partner (.scl(SCL_IN), .sda(SDA_IN), .nack(nack), .stretch(stretch),
        .scl_oe(p_scl), .sda_oe(p_sda), .got(p_got), .nbytes(p_n));
    always #12.5 CLOCK = !CLOCK;
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_errors = n_errors + 1;
            test_done();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int n = 1);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic push(input logic [7:0] d);
        TX_DATA = d;
        TX_VALID = 1;
        for (k = 0; k < 20000; k++) begin
            @(posedge CLOCK);
            if (TX_READY === 1'b1) break;
        end
        #1;
        TX_VALID = 0;
        tick();
    endtask
    task automatic pulse_start;
        START_REQUEST_SET = 1;
        tick();
        START_REQUEST_SET = 0;
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Each received byte against the bench queue
    always @(p_n) if (sent.size() > 0) chk("byte", sent.pop_front(), p_got);
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        tick(12);
        ARST_N = 1;
        tick();
        pulse_start();
        tick();
        chk("receiver start", 8'h0, 8'(START_REQUEST));
        TRANSMITTER_SELECT = 1;
        om_sda = 1;
        tick(100);
        om_scl = 1;
        tick(10);
        chk("flags", 8'h1, 8'(EVENT_FLAGS));
        pulse_start();
        tick(2000);
        chk("waiting", 8'h2, 8'({START_REQUEST, SDA_OE}));
        om_scl = 0;
        tick(100);
        om_sda = 0;
        for (k = 0; k < 3000 && START_REQUEST; k++) tick();
        chk("start sent", 8'h0, 8'(START_REQUEST));
        stretch = 16'd2000;
        for (i = 0; i < 3; i++) begin
            b = $random(seed);
            sent.push_back(b);
            push(b);
        end
        tick();
        chk("buffer full", 8'h0, 8'(TX_READY));
        for (k = 0; k < 40000 && p_n < 3; k++) tick();
        STOP_REQUEST_SET = 1;
        tick();
        STOP_REQUEST_SET = 0;
        for (k = 0; k < 3000 && STOP_REQUEST; k++) tick();
        tick(20);
        chk("after stop", 8'h2, 8'({BUS_BUSY_FLAG, EVENT_FLAGS}));
        chk("pin levels", 8'h0, 8'({SCL_OUT, SDA_OUT}));
        nack = 1;
        pulse_start();
        for (k = 0; k < 3000 && START_REQUEST; k++) tick();
        b = $random(seed);
        sent.push_back(b);
        push(b);
        for (k = 0; k < 20000 && EVENT_FLAGS !== 3'h6; k++) tick();
        chk("nack flags", 8'h6, 8'(EVENT_FLAGS));
        IRQ_EN = 3'h3;
        tick(2);
        chk("irq", 8'h16, 8'({IRQ_TAKEN, IRQ_PENDING, EVENT_FLAGS}));
        IRQ_EN = 3'h0;
        GLOBAL_IRQ_ENABLE = 1;
        tick();
        IRQ_EN = 3'h3;
        tick(2);
        chk("irq", 8'h56, 8'({IRQ_TAKEN, IRQ_PENDING, EVENT_FLAGS}));
        FLAG_CLEAR = 3'h2;
        tick();
        FLAG_CLEAR = 3'h0;
        tick(2);
        chk("irq", 8'h04, 8'({IRQ_TAKEN, IRQ_PENDING, EVENT_FLAGS}));
        MODE = 2'h1;
        tick();
        UART_RX = 0;
        tick(4);
        chk("rx busy", 8'h1, 8'(UNIT_BUSY_FLAG));
        tick(343);
        UART_RX = 1;
        tick(2700);
        chk("rx busy", 8'h1, 8'(UNIT_BUSY_FLAG));
        tick(500);
        chk("rx idle", 8'h0, 8'(UNIT_BUSY_FLAG));
        UART_RX = 0;
        tick(100);
        SOFT_RESET = 1;
        tick(3);
        chk("soft reset", 8'h0, 8'(UNIT_BUSY_FLAG));
        UART_RX = 1;
        tick(400);
        SOFT_RESET = 0;
        MODE = 2'h2;
        tick(2);
        for (i = 0; i < 2; i++) begin
            MSB_FIRST_SELECT = !i[0];
            b = $random(seed);
            TXB_DATA = b;
            TXB_WRITE = 1;
            tick();
            TXB_WRITE = 0;
            tick();
            chk("readback", b, TXB_READBACK);
            #7;
            for (k = 0; k < 8; k++) begin
                SPI_CLK = 1;
                #100;
                SPI_CLK = 0;
                got[MSB_FIRST_SELECT ? 7 - k : k] = SPI_MISO;
                #100;
            end
            tick();
            chk("spi byte", b, got);
        end
        test_done();
    end
endmodule // tb_scu_serial_unit
`default_nettype wire
